//--- src/lpd_pwm.sv
// PWM duty and polarity logic for sixteen open-drain LED outputs and a seventeenth output,
// with an AXI4-Lite register slave. Assumes the blink phase comes in from blink timing
// logic elsewhere and that pin wires are resolved outside from output enables.
`timescale 1ns/10ps
`include "lpd_regs.svh"

module lpd_pwm #(
	parameter int STEP_DIV = 1
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  wire lpd_pkg::lpd_axi_req_s  s_axi_req,
	output lpd_pkg::lpd_axi_rsp_s       s_axi_rsp,
	input  wire logic                   blink_phase,
	input  wire logic [16:0]            pin_in,
	output logic [16:0]                 pin_out,
	output logic [16:0]                 pin_oe_n
);

	lpd_pkg::lpd_axi_rsp_s rsp_ff,   nxt_rsp;
	lpd_pkg::lpd_regs_s    regs_ff,  nxt_regs;
	logic                  awv_ff,   nxt_awv;
	logic [7:0]            awa_ff,   nxt_awa;
	logic                  wv_ff,    nxt_wv;
	logic [31:0]           wd_ff,    nxt_wd;
	logic [3:0]            ws_ff,    nxt_ws;
	logic [15:0]           div_ff,   nxt_div;
	logic [3:0]            cyc_ff,   nxt_cyc;
	logic [3:0]            ts_ff,    nxt_ts;
	logic [16:0]           oe_n_ff,  nxt_oe_n;
	logic [16:0]           pout_ff;
	logic [16:0]           act_w;
	logic [3:0]            eff_w [17];
	logic                  wr_hit;
	logic [31:0]           mrg;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Word returned for a register read; unmapped addresses flag an error
	function automatic logic [32:0] rd_word(input logic [7:0] a, input lpd_pkg::lpd_regs_s r,
		input logic [16:0] pins, input logic [3:0] ts, input logic [3:0] cyc);
		logic [32:0] v;
		v = {1'h0, 32'h00000000};
		case (a)
			`LPD_OFF_PHASE0:    v[16:0] = r.phase0;
			`LPD_OFF_PHASE1:    v[16:0] = r.phase1;
			`LPD_OFF_MASTER:    v[7:0]  = {r.master, r.global_int};
			`LPD_OFF_CONFIG:    v[1:0]  = {r.global_en, r.blink_en};
			`LPD_OFF_INT_LO:    v[31:0] = r.ints[31:0];
			`LPD_OFF_INT_HI:    v[31:0] = r.ints[63:32];
			`LPD_OFF_PIN_STATE: v[16:0] = pins;
			`LPD_OFF_PWM_POS:   v[7:0]  = {ts, cyc};
			default:            v[32]   = 1'h1;
		endcase
		return v;
	endfunction

	// Bus slave and register file; address and data may arrive in either order
	always_comb begin
		nxt_rsp  = rsp_ff;
		nxt_regs = regs_ff;
		nxt_awv  = awv_ff;
		nxt_awa  = awa_ff;
		nxt_wv   = wv_ff;
		nxt_wd   = wd_ff;
		nxt_ws   = ws_ff;
		wr_hit   = 1'h1;
		mrg      = 32'h00000000;
		if (s_axi_req.awvalid && rsp_ff.awready) begin
			nxt_awv = 1'h1;
			nxt_awa = s_axi_req.awaddr[7:0];
		end
		if (s_axi_req.wvalid && rsp_ff.wready) begin
			nxt_wv = 1'h1;
			nxt_wd = s_axi_req.wdata;
			nxt_ws = s_axi_req.wstrb;
		end
		if (rsp_ff.bvalid && s_axi_req.bready) begin
			nxt_rsp.bvalid = 1'h0;
		end
		// Commit only once the previous response is gone, so answers never overlap
		if (awv_ff && wv_ff && !rsp_ff.bvalid) begin
			case (awa_ff)
				`LPD_OFF_PHASE0: begin
					mrg = merge({15'h0000, regs_ff.phase0}, wd_ff, ws_ff);
					nxt_regs.phase0 = mrg[16:0];
				end
				`LPD_OFF_PHASE1: begin
					mrg = merge({15'h0000, regs_ff.phase1}, wd_ff, ws_ff);
					nxt_regs.phase1 = mrg[16:0];
				end
				`LPD_OFF_MASTER: begin
					mrg = merge({24'h000000, regs_ff.master, regs_ff.global_int}, wd_ff, ws_ff);
					nxt_regs.master     = mrg[`LPD_MASTER_LSB +: 4];
					nxt_regs.global_int = mrg[`LPD_GLOBAL_LSB +: 4];
				end
				`LPD_OFF_CONFIG: begin
					mrg = merge({30'h00000000, regs_ff.global_en, regs_ff.blink_en}, wd_ff, ws_ff);
					nxt_regs.blink_en  = mrg[`LPD_CFG_BLINK_BIT];
					nxt_regs.global_en = mrg[`LPD_CFG_GLOBAL_BIT];
				end
				`LPD_OFF_INT_LO: nxt_regs.ints[31:0]  = merge(regs_ff.ints[31:0], wd_ff, ws_ff);
				`LPD_OFF_INT_HI: nxt_regs.ints[63:32] = merge(regs_ff.ints[63:32], wd_ff, ws_ff);
				`LPD_OFF_PIN_STATE, `LPD_OFF_PWM_POS: wr_hit = 1'h1;
				default: wr_hit = 1'h0;
			endcase
			nxt_awv        = 1'h0;
			nxt_wv         = 1'h0;
			nxt_rsp.bvalid = 1'h1;
			nxt_rsp.bresp  = wr_hit ? `LPD_RESP_OKAY : `LPD_RESP_SLVERR;
		end
		nxt_rsp.awready = !nxt_awv;
		nxt_rsp.wready  = !nxt_wv;
		if (rsp_ff.rvalid && s_axi_req.rready) begin
			nxt_rsp.rvalid = 1'h0;
		end
		if (s_axi_req.arvalid && rsp_ff.arready) begin
			{nxt_rsp.rresp[1], nxt_rsp.rdata} = rd_word(s_axi_req.araddr[7:0], regs_ff, pin_in,
				ts_ff, cyc_ff);
			nxt_rsp.rresp[0] = 1'h0;
			nxt_rsp.rvalid   = 1'h1;
		end
		nxt_rsp.arready = !nxt_rsp.rvalid;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rsp_ff           <= '0;
			rsp_ff.awready   <= 1'h1;
			rsp_ff.wready    <= 1'h1;
			rsp_ff.arready   <= 1'h1;
			regs_ff.phase0   <= `LPD_RST_PHASE;
			regs_ff.phase1   <= `LPD_RST_PHASE;
			regs_ff.master   <= `LPD_MASTER_OFF;
			regs_ff.global_int <= `LPD_RST_INT;
			regs_ff.blink_en <= `LPD_RST_FLAG;
			regs_ff.global_en <= `LPD_RST_FLAG;
			regs_ff.ints     <= '0;
			awv_ff           <= 1'h0;
			awa_ff           <= 8'h00;
			wv_ff            <= 1'h0;
			wd_ff            <= 32'h00000000;
			ws_ff            <= 4'h0;
		end else begin
			rsp_ff  <= nxt_rsp;
			regs_ff <= nxt_regs;
			awv_ff  <= nxt_awv;
			awa_ff  <= nxt_awa;
			wv_ff   <= nxt_wv;
			wd_ff   <= nxt_wd;
			ws_ff   <= nxt_ws;
		end
	end

	// PWM position: step divider, cycle within slot, master timeslot
	always_comb begin
		nxt_div = div_ff;
		nxt_cyc = cyc_ff;
		nxt_ts  = ts_ff;
		// Master zero freezes the oscillator; nothing moves and power stays lowest
		if (regs_ff.master != `LPD_MASTER_OFF) begin
			if (div_ff >= 16'(STEP_DIV - 1)) begin
				nxt_div = 16'h0000;
				nxt_cyc = cyc_ff + 4'h1;
				if (cyc_ff == `LPD_SLOT_LAST) begin
					nxt_ts = (ts_ff >= `LPD_NUM_SLOTS_LAST) ? 4'h0 : ts_ff + 4'h1;
				end
			end else begin
				nxt_div = div_ff + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_ff <= 16'h0000;
			cyc_ff <= 4'h0;
			ts_ff  <= 4'h0;
		end else begin
			div_ff <= nxt_div;
			cyc_ff <= nxt_cyc;
			ts_ff  <= nxt_ts;
		end
	end

	// Active polarity bit and effective setting per output
	for (genvar i = 0; i < 17; i++) begin : g_out
		assign act_w[i] = (regs_ff.blink_en && blink_phase) ? regs_ff.phase1[i]
			: regs_ff.phase0[i];
		if (i < `LPD_NUM_OUT) begin : g_ind
			assign eff_w[i] = regs_ff.global_en ? regs_ff.global_int
				: regs_ff.ints[i*4 +: 4];
		end else begin : g_top
			assign eff_w[i] = regs_ff.global_int; // The seventeenth output always uses the global setting
		end
	end

	// Pin drive: enable low sinks the pin, high leaves it high-impedance
	always_comb begin
		nxt_oe_n = oe_n_ff;
		for (int i = 0; i < 17; i++) begin
			if (eff_w[i] == `LPD_INT_STATIC) begin
				nxt_oe_n[i] = act_w[i];
			end else if (regs_ff.master == `LPD_MASTER_OFF || ts_ff >= regs_ff.master) begin
				nxt_oe_n[i] = !act_w[i];
			end else begin
				// Active level for cycles 0..n, then the opposite level
				nxt_oe_n[i] = (cyc_ff <= eff_w[i]) ? act_w[i] : !act_w[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			oe_n_ff <= 17'h1FFFF;
			pout_ff <= 17'h00000;
		end else begin
			oe_n_ff <= nxt_oe_n;
			pout_ff <= 17'h00000; // Open drain: only ever pulls low
		end
	end

	assign pin_oe_n  = oe_n_ff;
	assign pin_out   = pout_ff;
	assign s_axi_rsp = rsp_ff;

	// Checks on output 0 and on the PWM position counters
	a_phase0_only: assert property (@(posedge clk_sys) disable iff (rst)
		!regs_ff.blink_en |-> act_w[0] == regs_ff.phase0[0])
		else $error("Blink off but polarity not from phase 0");
	a_blink_phase1: assert property (@(posedge clk_sys) disable iff (rst)
		regs_ff.blink_en && blink_phase |-> act_w[0] == regs_ff.phase1[0])
		else $error("Blink phase 1 polarity wrong");
	a_pwm_sink: assert property (@(posedge clk_sys) disable iff (rst)
		eff_w[0] != `LPD_INT_STATIC && !act_w[0] && ts_ff < regs_ff.master && cyc_ff <= eff_w[0]
		|=> !pin_oe_n[0])
		else $error("Output not sinking during on-time");
	a_pwm_release: assert property (@(posedge clk_sys) disable iff (rst)
		eff_w[0] != `LPD_INT_STATIC && act_w[0] && ts_ff < regs_ff.master && cyc_ff <= eff_w[0]
		|=> pin_oe_n[0])
		else $error("Output not released during on-time");
	a_slot_tail: assert property (@(posedge clk_sys) disable iff (rst)
		eff_w[0] != `LPD_INT_STATIC && ts_ff < regs_ff.master && cyc_ff > eff_w[0]
		|=> pin_oe_n[0] == !$past(act_w[0]))
		else $error("Slot tail level wrong");
	a_static_low: assert property (@(posedge clk_sys) disable iff (rst)
		eff_w[0] == `LPD_INT_STATIC && !act_w[0] |=> !pin_oe_n[0])
		else $error("Static low not held");
	a_static_hiz: assert property (@(posedge clk_sys) disable iff (rst)
		eff_w[0] == `LPD_INT_STATIC && act_w[0] |=> pin_oe_n[0])
		else $error("Static high impedance not held");
	a_period_wrap: assert property (@(posedge clk_sys) disable iff (rst)
		regs_ff.master != `LPD_MASTER_OFF && div_ff >= 16'(STEP_DIV - 1) && cyc_ff == 4'hF
		&& ts_ff == 4'hE |=> cyc_ff == 4'h0 && ts_ff == 4'h0)
		else $error("PWM period did not wrap after 240 steps");
	a_gate_off: assert property (@(posedge clk_sys) disable iff (rst)
		eff_w[0] != `LPD_INT_STATIC && ts_ff >= regs_ff.master |=> pin_oe_n[0] == !$past(act_w[0]))
		else $error("Ungated timeslot still pulsing");
	a_osc_stop: assert property (@(posedge clk_sys) disable iff (rst)
		regs_ff.master == `LPD_MASTER_OFF |=> $stable(cyc_ff) && $stable(ts_ff))
		else $error("Oscillator runs with master zero");
	a_global_sel: assert property (@(posedge clk_sys) disable iff (rst)
		regs_ff.global_en |-> eff_w[0] == regs_ff.global_int)
		else $error("Global setting not applied");

endmodule

//--- pkg/lpd_regs.svh
// Register offsets, field positions, reset values and PWM counts of the LED PWM block.
// Included by the package and the design; holds definitions only.
`ifndef LPD_REGS_SVH
`define LPD_REGS_SVH

// Byte offsets on the register bus
`define LPD_OFF_PHASE0     8'h00
`define LPD_OFF_PHASE1     8'h04
`define LPD_OFF_MASTER     8'h08
`define LPD_OFF_CONFIG     8'h0C
`define LPD_OFF_INT_LO     8'h10
`define LPD_OFF_INT_HI     8'h14
`define LPD_OFF_PIN_STATE  8'h18
`define LPD_OFF_PWM_POS    8'h1C

// Field positions
`define LPD_MASTER_LSB     4
`define LPD_GLOBAL_LSB     0
`define LPD_CFG_BLINK_BIT  0
`define LPD_CFG_GLOBAL_BIT 1

// Reset values
`define LPD_RST_PHASE      17'h00000
`define LPD_RST_INT        4'h0
`define LPD_RST_FLAG       1'h0

// PWM geometry
`define LPD_NUM_OUT        16
`define LPD_SLOT_LAST      4'hF
`define LPD_NUM_SLOTS_LAST 4'hE
`define LPD_INT_STATIC     4'hF
`define LPD_MASTER_OFF     4'h0

// Bus answers
`define LPD_RESP_OKAY      2'h0
`define LPD_RESP_SLVERR    2'h2

`endif

//--- pkg/lpd_pkg.sv
// Types shared by the LED PWM block: register-bus carriers and the register file layout.
// Assumes the constants header is on the include path.
`include "lpd_regs.svh"

package lpd_pkg;

	// Master-to-slave AXI4-Lite signals
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic [2:0]  awprot;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic [2:0]  arprot;
		logic        rready;
	} lpd_axi_req_s;

	// Slave-to-master AXI4-Lite signals
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} lpd_axi_rsp_s;

	// Software-visible control state
	typedef struct packed {
		logic [16:0] phase0;
		logic [16:0] phase1;
		logic [3:0]  master;
		logic [3:0]  global_int;
		logic        blink_en;
		logic        global_en;
		logic [63:0] ints;
	} lpd_regs_s;

endpackage

//--- verification/lpd_load.sv
// Resistive pull-up load standing on every open-drain output pin.
// Assumes the design sinks a pin when its output enable is low.
`timescale 1ns/10ps

module lpd_load (
	input  wire logic [16:0] oe_n,
	output logic      [16:0] level
);
	// Released pin floats up; an unknown enable stays unknown so it cannot pass as a level
	always_comb begin
		for (int i = 0; i < 17; i++) begin
			level[i] = (oe_n[i] === 1'b0) ? 1'b0 : ((oe_n[i] === 1'b1) ? 1'b1 : 1'bx);
		end
	end
endmodule

//--- verification/led_pwm_duty_polarity_tb.sv
// Self-checking bench for the LED PWM block: duty, polarity, gating, global and blink.
// Assumes a pull-up load on every pin and a one-clock PWM step.
`timescale 1ns/10ps
`include "lpd_regs.svh"

module led_pwm_duty_polarity_tb;
	logic                  clk_sys;
	logic                  rst;
	logic                  blink_phase;
	logic [16:0]           pin_lvl;
	logic [16:0]           pin_out;
	logic [16:0]           pin_oe_n;
	lpd_pkg::lpd_axi_req_s req;
	lpd_pkg::lpd_axi_rsp_s rsp;
	int                    err_count = 0;
	int                    total_checks = 0;
	int                    cycles = 0;
	logic [1:0]            wr_resp;

	lpd_pwm #(.STEP_DIV(1)) dut (.clk_sys(clk_sys), .rst(rst), .s_axi_req(req),
		.s_axi_rsp(rsp), .blink_phase(blink_phase), .pin_in(pin_lvl),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n));
	lpd_load load (.oe_n(pin_oe_n), .level(pin_lvl));

	// Clock at 200 MHz
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Hang guard; the whole run needs about 2300 cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Write: address and data offered together, each released when its ready is seen
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk_sys);
		req.awaddr <= {24'h000000, a};
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'h1;
		req.wvalid <= 1'h1;
		req.bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_sys);
			if (!aw_ok && rsp.awready === 1'b1) begin
				aw_ok = 1'b1;
				req.awvalid <= 1'h0;
			end
			if (!w_ok && rsp.wready === 1'b1) begin
				w_ok = 1'b1;
				req.wvalid <= 1'h0;
			end
		end
		while (rsp.bvalid !== 1'b1) @(posedge clk_sys);
		// Response code is taken at the same edge that sees bvalid high
		wr_resp = rsp.bresp;
		req.bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		req.araddr <= {24'h000000, a};
		req.arvalid <= 1'h1;
		req.rready <= 1'h1;
		do @(posedge clk_sys); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'h0;
		while (rsp.rvalid !== 1'b1) @(posedge clk_sys);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'h0;
	endtask

	// Low clocks per 240-step period for active bit b, setting n, master m
	function automatic logic [31:0] exp_low(input logic b, input logic [3:0] n,
		input logic [3:0] m);
		int ni;
		int mi;
		ni = n;
		mi = m;
		if (n == 4'hF)
			return b ? 0 : 240;
		return b ? mi * (15 - ni) + (15 - mi) * 16 : mi * (ni + 1);
	endfunction

	// Any 240 consecutive steps hold one whole period, so no alignment is needed
	task automatic measure(input logic [16:0] act, input logic [3:0] m, input logic gen,
		input logic [3:0] g);
		int lows [17];
		logic [3:0] n;
		repeat (4) @(posedge clk_sys);
		foreach (lows[i]) lows[i] = 0;
		repeat (240) begin
			@(posedge clk_sys);
			for (int i = 0; i < 17; i++) if (pin_lvl[i] === 1'b0) lows[i]++;
		end
		for (int i = 0; i < 17; i++) begin
			n = (gen || i == 16) ? g : 4'(i);
			check("low time", lows[i], exp_low(act[i], n, m));
		end
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk_sys);
		check("oe_n after reset", {15'h0000, pin_oe_n}, 32'h0001FFFF);
		check("pin_out", {15'h0000, pin_out}, 32'h00000000);
		axi_rd(`LPD_OFF_PHASE0, d, r);
		check("phase0 reset", d, 32'h00000000);
		axi_rd(8'h20, d, r);
		check("unmapped resp", {30'h0, r}, {30'h0, `LPD_RESP_SLVERR});
		// Unmapped write is refused; a read-only register accepts and ignores it
		axi_wr(8'h20, 32'h000000FF);
		check("unmapped write resp", {30'h0, wr_resp}, {30'h0, `LPD_RESP_SLVERR});
		axi_wr(`LPD_OFF_PIN_STATE, 32'h0001FFFF);
		check("read-only write resp", {30'h0, wr_resp}, {30'h0, `LPD_RESP_OKAY});
		axi_rd(`LPD_OFF_PHASE0, d, r);
		check("phase0 untouched", d, 32'h00000000);
	endtask

	// Output i below 16 gets setting i, output 16 the global setting, so one period covers every setting
	task automatic t_duty();
		axi_wr(`LPD_OFF_INT_LO, 32'h76543210);
		axi_wr(`LPD_OFF_INT_HI, 32'hFEDCBA98);
		axi_wr(`LPD_OFF_MASTER, 32'h000000F3);
		measure(17'h00000, 4'hF, 1'h0, 4'h3);
		axi_wr(`LPD_OFF_PHASE0, 32'h0001FFFF);
		measure(17'h1FFFF, 4'hF, 1'h0, 4'h3);
	endtask

	task automatic t_master();
		logic [3:0] ms [3];
		logic [31:0] d;
		logic [31:0] d2;
		logic [1:0] r;
		ms = '{4'h1, 4'h7, 4'h0};
		axi_wr(`LPD_OFF_PHASE0, 32'h0000F0F0);
		foreach (ms[k]) begin
			axi_wr(`LPD_OFF_MASTER, {24'h000000, ms[k], 4'h3});
			measure(17'h0F0F0, ms[k], 1'h0, 4'h3);
		end
		// Master still zero here: position must not move between two reads
		axi_rd(`LPD_OFF_PWM_POS, d, r);
		repeat (20) @(posedge clk_sys);
		axi_rd(`LPD_OFF_PWM_POS, d2, r);
		check("frozen position", d2, d);
		// Static levels: opposite of the active bit, output 15 at setting 0xF follows it
		axi_rd(`LPD_OFF_PIN_STATE, d, r);
		check("pin state", d, 32'h00018F0F);
	endtask

	task automatic t_global();
		axi_wr(`LPD_OFF_CONFIG, 32'h00000002);
		axi_wr(`LPD_OFF_MASTER, 32'h000000F5);
		measure(17'h0F0F0, 4'hF, 1'h1, 4'h5);
	endtask

	// Blink phase high must be ignored until blinking is enabled
	task automatic t_blink();
		axi_wr(`LPD_OFF_CONFIG, 32'h00000000);
		axi_wr(`LPD_OFF_PHASE0, 32'h00000000);
		axi_wr(`LPD_OFF_PHASE1, 32'h0001FFFF);
		blink_phase <= 1'h1;
		measure(17'h00000, 4'hF, 1'h0, 4'h5);
		axi_wr(`LPD_OFF_CONFIG, 32'h00000001);
		measure(17'h1FFFF, 4'hF, 1'h0, 4'h5);
		blink_phase <= 1'h0;
		measure(17'h00000, 4'hF, 1'h0, 4'h5);
	endtask

	// Main sequence
	initial begin
		rst = 1'h1;
		req = '0;
		blink_phase = 1'h0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
		t_reset();
		t_duty();
		t_master();
		t_global();
		t_blink();
		results();
	end
endmodule
